// ==== src/oss_pkg.sv ====
/*
 oscillator source select package: field codes, mode enumeration and the
 decoded clock selection carrier. assumes nothing of its surroundings.
*/
package oss_pkg;
   // initial_clock_source_field codes
   localparam logic [2:0] OSS_SRC_FAST_RC_DIVN = 3'h7;
   localparam logic [2:0] OSS_SRC_FAST_RC_DIV16 = 3'h6;
   localparam logic [2:0] OSS_SRC_LOW_POWER_RC = 3'h5;
   localparam logic [2:0] OSS_SRC_RSVD = 3'h4;
   localparam logic [2:0] OSS_SRC_PRI_PLL = 3'h3;
   localparam logic [2:0] OSS_SRC_PRI = 3'h2;
   localparam logic [2:0] OSS_SRC_FAST_RC_PLL = 3'h1;
   localparam logic [2:0] OSS_SRC_FAST_RC = 3'h0;
   // erased configuration cells read as ones
   localparam logic [2:0] OSS_SRC_ERASED = 3'h7;
   localparam logic [1:0] OSS_PRI_ERASED = 2'h3;
   localparam logic OSS_PIN_FN_ERASED = 1'h1;
   // primary_crystal_mode_field codes
   localparam logic [1:0] OSS_PRI_EC = 2'h0;
   localparam logic [1:0] OSS_PRI_XT = 2'h1;
   localparam logic [1:0] OSS_PRI_HS = 2'h2;
   localparam logic [1:0] OSS_PRI_RSVD = 2'h3;

   typedef enum logic [3:0] {
      OSS_MODE_FAST_RC_DIVN,
      OSS_MODE_FAST_RC_DIV16,
      OSS_MODE_LOW_POWER_RC,
      OSS_MODE_HS_PLL,
      OSS_MODE_XT_PLL,
      OSS_MODE_EC_PLL,
      OSS_MODE_HS,
      OSS_MODE_XT,
      OSS_MODE_EC,
      OSS_MODE_FAST_RC_PLL,
      OSS_MODE_FAST_RC,
      OSS_MODE_RESERVED
   } oss_mode_t;

   typedef struct packed {
      logic [2:0] src;
      logic [1:0] pri;
      logic pin_fn;
   } oss_cfg_t;

   typedef struct packed {
      oss_mode_t mode;
      logic use_fast_rc;
      logic use_low_power_rc;
      logic use_primary;
      logic use_pll;
      logic use_divn;
      logic use_div16;
      logic pin_by_fn_bit;
      logic pin_as_gpio;
      logic reserved;
   } oss_sel_t;
endpackage : oss_pkg

// ==== src/oss_select.sv ====
/*
 oscillator source select: decodes the configuration fields into one
 system clock source and the role of the second oscillator pin.
 assumes cfg_load pulses once when configuration has been read out of
 non-volatile storage after reset; cfg is stable while cfg_load is high.
*/
`timescale 1ns/100ps
// Contract
// - select 111: fast rc via programmable divide-by-n, mode ignored.
// - select 110: fast rc divided by sixteen, mode field ignored.
// - select 101: low-power rc oscillator, mode field ignored.
// - select 011: primary through pll; mode 10 hs, 01 xt, 00 ec.
// - select 010: primary direct without pll, same sub-mode encodings.
// - select 001: fast rc through divide-by-n then pll.
// - select 000: undivided fast rc directly.
// - erased device decodes to fast rc divide-by-n mode.
// - internal and ec modes: second pin role set by pin-function bit.
module oss_select
   import oss_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cfg_load,
   input wire oss_cfg_t cfg,
   output oss_sel_t sel,
   output logic loaded
);

   typedef struct packed {
      oss_sel_t sel;
      logic loaded;
   } oss_state_t;

   oss_state_t state_q;
   oss_state_t state_d;

   function automatic oss_sel_t oss_decode(input oss_cfg_t c);
      oss_sel_t s;
      s = '0;
      s.mode = OSS_MODE_RESERVED;
      s.reserved = 1'b1;
      unique case (c.src)
         OSS_SRC_FAST_RC_DIVN: begin
            s.mode = OSS_MODE_FAST_RC_DIVN;
            s.use_fast_rc = 1'b1;
            s.use_divn = 1'b1;
            s.reserved = 1'b0;
         end
         OSS_SRC_FAST_RC_DIV16: begin
            s.mode = OSS_MODE_FAST_RC_DIV16;
            s.use_fast_rc = 1'b1;
            s.use_div16 = 1'b1;
            s.reserved = 1'b0;
         end
         OSS_SRC_LOW_POWER_RC: begin
            s.mode = OSS_MODE_LOW_POWER_RC;
            s.use_low_power_rc = 1'b1;
            s.reserved = 1'b0;
         end
         OSS_SRC_PRI_PLL: begin
            s.use_primary = 1'b1;
            s.use_pll = 1'b1;
            s.reserved = (c.pri == OSS_PRI_RSVD);
            unique case (c.pri)
               OSS_PRI_HS: s.mode = OSS_MODE_HS_PLL;
               OSS_PRI_XT: s.mode = OSS_MODE_XT_PLL;
               OSS_PRI_EC: s.mode = OSS_MODE_EC_PLL;
               OSS_PRI_RSVD: s.mode = OSS_MODE_RESERVED;
            endcase
         end
         OSS_SRC_PRI: begin
            s.use_primary = 1'b1;
            s.reserved = (c.pri == OSS_PRI_RSVD);
            unique case (c.pri)
               OSS_PRI_HS: s.mode = OSS_MODE_HS;
               OSS_PRI_XT: s.mode = OSS_MODE_XT;
               OSS_PRI_EC: s.mode = OSS_MODE_EC;
               OSS_PRI_RSVD: s.mode = OSS_MODE_RESERVED;
            endcase
         end
         OSS_SRC_FAST_RC_PLL: begin
            s.mode = OSS_MODE_FAST_RC_PLL;
            s.use_fast_rc = 1'b1;
            s.use_divn = 1'b1;
            s.use_pll = 1'b1;
            s.reserved = 1'b0;
         end
         OSS_SRC_FAST_RC: begin
            s.mode = OSS_MODE_FAST_RC;
            s.use_fast_rc = 1'b1;
            s.reserved = 1'b0;
         end
         OSS_SRC_RSVD: begin
            s.mode = OSS_MODE_RESERVED;
            s.reserved = 1'b1;
         end
      endcase
      s.pin_by_fn_bit = !s.reserved &&
         (!s.use_primary || c.pri == OSS_PRI_EC);
      s.pin_as_gpio = s.pin_by_fn_bit && !c.pin_fn;
      return s;
   endfunction : oss_decode

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      if (cfg_load) begin
         state_d.sel = oss_decode(cfg);
         state_d.loaded = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q.sel <= '{mode: OSS_MODE_FAST_RC_DIVN, use_fast_rc: 1'b1,
                          use_low_power_rc: 1'b0, use_primary: 1'b0,
                          use_pll: 1'b0, use_divn: 1'b1,
                          use_div16: 1'b0, pin_by_fn_bit: 1'b1,
                          pin_as_gpio: 1'b0, reserved: 1'b0};
         state_q.loaded <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign sel = state_q.sel;
   assign loaded = state_q.loaded;

   ////////////////////////////////////////////////////////////////////////
   property p_divn;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_FAST_RC_DIVN |=> sel.mode ==
         OSS_MODE_FAST_RC_DIVN && sel.use_divn && !sel.use_pll;
   endproperty
   a_divn: assert property (p_divn) else $error("divn decode wrong");

   property p_div16;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_FAST_RC_DIV16 |=> sel.use_div16 &&
         sel.use_fast_rc && !sel.use_divn;
   endproperty
   a_div16: assert property (p_div16) else $error("div16 wrong");

   property p_low_power_rc;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_LOW_POWER_RC |=> sel.use_low_power_rc
         && sel.mode == OSS_MODE_LOW_POWER_RC
         && !sel.use_fast_rc && !sel.reserved;
   endproperty
   a_low_power_rc: assert property (p_low_power_rc)
      else $error("low-power rc decode wrong");

   property p_pri_pll;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_PRI_PLL && cfg.pri == OSS_PRI_HS
         |=> sel.mode == OSS_MODE_HS_PLL && sel.use_pll;
   endproperty
   a_pri_pll: assert property (p_pri_pll) else $error("hs pll");

   property p_pri;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_PRI && cfg.pri == OSS_PRI_XT
         |=> sel.mode == OSS_MODE_XT && !sel.use_pll;
   endproperty
   a_pri: assert property (p_pri) else $error("xt direct wrong");

   property p_fast_rc_pll;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_FAST_RC_PLL |=> sel.use_pll &&
         sel.use_divn && sel.use_fast_rc;
   endproperty
   a_fast_rc_pll: assert property (p_fast_rc_pll)
      else $error("fast rc pll decode wrong");

   property p_fast_rc;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_FAST_RC |=> sel.mode ==
         OSS_MODE_FAST_RC && !sel.use_divn && !sel.use_pll;
   endproperty
   a_fast_rc: assert property (p_fast_rc)
      else $error("fast rc decode wrong");

   property p_erased;
      @(posedge core_clk) disable iff (!rst_n)
      !loaded |-> sel.mode == OSS_MODE_FAST_RC_DIVN && sel.use_divn;
   endproperty
   a_erased: assert property (p_erased) else $error("not erased");

   property p_pin;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_PRI && cfg.pri == OSS_PRI_HS
         |=> !sel.pin_by_fn_bit && !sel.pin_as_gpio;
   endproperty
   a_pin: assert property (p_pin) else $error("pin role wrong");

   property p_ec_pin;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_PRI_PLL && cfg.pri == OSS_PRI_EC
         |=> sel.mode == OSS_MODE_EC_PLL && sel.pin_by_fn_bit &&
         sel.pin_as_gpio == !$past(cfg.pin_fn);
   endproperty
   a_ec_pin: assert property (p_ec_pin)
      else $error("ec pin role wrong");

   property p_rsvd;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_RSVD |=> sel.reserved &&
         sel.mode == OSS_MODE_RESERVED && !sel.use_primary &&
         !sel.use_fast_rc && !sel.use_low_power_rc && !sel.pin_by_fn_bit;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved select");

   property p_rsvd_pri;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_load && cfg.src == OSS_SRC_PRI && cfg.pri == OSS_PRI_RSVD
         |=> sel.reserved && sel.mode == OSS_MODE_RESERVED &&
         sel.use_primary && !sel.pin_by_fn_bit;
   endproperty
   a_rsvd_pri: assert property (p_rsvd_pri)
      else $error("reserved primary mode");

endmodule : oss_select

// ==== testbench/oss_select_tb.sv ====
/*
 self-checking bench for oss_select: loads configuration codes and
 compares the registered decode against values built here.
 assumes the decode stands until the next load and needs no partner.
*/
`timescale 1ns/100ps
module oss_select_tb
   import oss_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cfg_load = 1'b0;
   oss_cfg_t cfg = '0;
   oss_sel_t sel;
   logic loaded;
   int miscompares = 0;
   int check_count = 0;

   oss_select DUT (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cfg_load(cfg_load),
      .cfg(cfg),
      .sel(sel),
      .loaded(loaded)
   );

   always #5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t decode got %h expected %h", $time, got, exp);
      end
   endtask : check

   function automatic oss_sel_t exp_sel(input oss_cfg_t c);
      oss_sel_t e;
      e = '0;
      e.mode = OSS_MODE_RESERVED;
      case (c.src)
         3'h7: begin
            e.mode = OSS_MODE_FAST_RC_DIVN;
            e.use_fast_rc = 1'b1;
            e.use_divn = 1'b1;
         end
         3'h6: begin
            e.mode = OSS_MODE_FAST_RC_DIV16;
            e.use_fast_rc = 1'b1;
            e.use_div16 = 1'b1;
         end
         3'h5: begin
            e.mode = OSS_MODE_LOW_POWER_RC;
            e.use_low_power_rc = 1'b1;
         end
         3'h3, 3'h2: begin
            e.use_primary = 1'b1;
            e.use_pll = (c.src == 3'h3);
            case (c.pri)
               2'h2: e.mode = e.use_pll ? OSS_MODE_HS_PLL : OSS_MODE_HS;
               2'h1: e.mode = e.use_pll ? OSS_MODE_XT_PLL : OSS_MODE_XT;
               2'h0: e.mode = e.use_pll ? OSS_MODE_EC_PLL : OSS_MODE_EC;
               default: e.reserved = 1'b1;
            endcase
         end
         3'h1: begin
            e.mode = OSS_MODE_FAST_RC_PLL;
            e.use_fast_rc = 1'b1;
            e.use_divn = 1'b1;
            e.use_pll = 1'b1;
         end
         3'h0: begin
            e.mode = OSS_MODE_FAST_RC;
            e.use_fast_rc = 1'b1;
         end
         default: e.reserved = 1'b1;
      endcase
      e.pin_by_fn_bit = !e.reserved && (!e.use_primary || c.pri == 2'h0);
      e.pin_as_gpio = e.pin_by_fn_bit && !c.pin_fn;
      return e;
   endfunction : exp_sel

   // one load pulse, then wait past the answer cycle
   task automatic do_load(input oss_cfg_t c);
      @(posedge core_clk);
      cfg_load <= 1'b1;
      cfg <= c;
      @(posedge core_clk);
      cfg_load <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask : do_load

   task automatic load_check(input oss_cfg_t c);
      do_load(c);
      check({3'h0, sel}, {3'h0, exp_sel(c)});
      check({15'h0, loaded}, 16'h1);
   endtask : load_check

   ////////////////////////////////////////////////////////////////////////
   task automatic t_erased();
      oss_cfg_t e;
      e = '{OSS_SRC_ERASED, OSS_PRI_ERASED, OSS_PIN_FN_ERASED};
      #1;
      check({3'h0, sel}, {3'h0, exp_sel(e)});
      check({15'h0, loaded}, 16'h0);
      load_check(e);
   endtask : t_erased

   task automatic t_internal();
      logic [2:0] srcs [5] = '{3'h7, 3'h6, 3'h5, 3'h1, 3'h0};
      for (int i = 0; i < 5; i++) begin
         for (int p = 0; p < 4; p++) begin
            load_check('{srcs[i], p[1:0], p[0]});
         end
      end
   endtask : t_internal

   task automatic t_primary();
      for (int s = 2; s < 4; s++) begin
         for (int p = 0; p < 3; p++) begin
            load_check('{s[2:0], p[1:0], 1'b0});
            load_check('{s[2:0], p[1:0], 1'b1});
         end
      end
   endtask : t_primary

   task automatic t_reserved();
      load_check('{3'h4, 2'h1, 1'b0});
      load_check('{3'h3, 2'h3, 1'b0});
      load_check('{3'h2, 2'h3, 1'b1});
      @(posedge core_clk);
      cfg_load <= 1'b1;
      cfg <= '{3'h4, 2'h0, 1'b0};
      @(posedge core_clk);
      cfg <= '{3'h2, 2'h1, 1'b0};
      @(posedge core_clk);
      cfg_load <= 1'b0;
      @(posedge core_clk);
      #1;
      check({3'h0, sel}, {3'h0, exp_sel('{3'h2, 2'h1, 1'b0})});
   endtask : t_reserved

   // second reset returns to erased decode
   task automatic t_rereset();
      load_check('{3'h5, 2'h0, 1'b0});
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check({3'h0, sel}, {3'h0, exp_sel('{3'h7, 2'h3, 1'b1})});
      check({15'h0, loaded}, 16'h0);
      @(posedge core_clk);
      rst_n <= 1'b1;
   endtask : t_rereset

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      t_erased();
      t_internal();
      t_primary();
      t_reserved();
      t_rereset();
      t_erased();
      end_of_test();
   end

   initial begin
      #200us;
      miscompares++;
      end_of_test();
   end
endmodule : oss_select_tb
